/* mrs_pkg.sv */
// package for the reset sequencer: constants, register map and carrier structs
`default_nettype none
package mrs_pkg;
  // e clock runs at the system clock rate (250 mhz, 4 ns)
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam logic [3:0] PIN_DRIVE_CYCLES = 4'h4;
  localparam logic [3:0] PIN_SAMPLE_DELAY = 4'h2;
  localparam logic [3:0] SYNC_LATENCY = 4'h2;
  localparam int unsigned POR_CYCLES = 4064;
  localparam logic [2:0] VECTOR_CYCLES = 3'h3;
  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] VECTOR_OFFSET = 8'h08;
  localparam logic [7:0] INITV_OFFSET = 8'h0c;
  // control register fields
  localparam int unsigned CTRL_WDOG_BIT = 0;
  localparam int unsigned CTRL_CLKMON_BIT = 1;
  localparam int unsigned CTRL_BOOT_BIT = 2;
  localparam int unsigned CTRL_EXPAND_BIT = 3;
  // reset values of peripheral state, reset vectors, boot rom base and bus responses
  localparam logic [7:0] INIT_RESET = 8'h01;
  localparam logic [7:0] PORTC_DIR_RESET = 8'h00;
  localparam logic [15:0] TIMER_COUNT_RESET = 16'h0000;
  localparam logic [15:0] COMPARE_RESET = 16'hffff;
  localparam logic [15:0] VEC_RESTART = 16'hfffe;
  localparam logic [15:0] VEC_SPECIAL = 16'hbffe;
  localparam logic [15:0] VEC_WDOG = 16'hfffa;
  localparam logic [15:0] VEC_CLKMON = 16'hfffc;
  localparam logic [15:0] VEC_WDOG_SPECIAL = 16'hbffa;
  localparam logic [15:0] VEC_CLKMON_SPECIAL = 16'hbffc;
  localparam logic [15:0] BOOT_ROM_BASE = 16'hbf40;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {CAUSE_EXT, CAUSE_POR, CAUSE_WDOG, CAUSE_CLKMON} mrs_cause_t;
  typedef enum logic [2:0] {ST_POR, ST_DRIVE, ST_WAIT, ST_HOLD, ST_FETCH, ST_RUN} mrs_state_t;

  // forced reset levels for all peripheral controls
  typedef struct packed {
    logic ccr_x_mask;
    logic ccr_i_mask;
    logic stop_disable;
    logic [7:0] init_map;
    logic expansion_bus;
    logic strobe_a_flag;
    logic strobe_a_irq_enable;
    logic handshake_select;
    logic portc_open_drain;
    logic [7:0] port_c_direction;
    logic strobe_a_edge_select;
    logic strobe_b_invert;
    logic [7:0] port_b_out;
    logic [15:0] timer_count;
    logic [15:0] compare_value;
    logic [1:0] prescaler;
    logic [7:0] compare1_pin_mask;
    logic timer_clear;
    logic periodic_interrupt_clear;
    logic pulse_input_enable;
    logic watchdog_timer_enable;
    logic [1:0] watchdog_rate;
    logic sci_clear;
    logic tx_buffer_empty;
    logic tx_complete;
    logic rx_clear;
    logic spi_enable;
    logic converter_power_up;
    logic converter_done_clear;
  } mrs_periph_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } mrs_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mrs_axi_rsp_t;
endpackage
`default_nettype wire

/* mrs_sequencer.sv */
// reset sequencer: source gathering, pin drive and sampling, vector select
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`default_nettype none
module mrs_sequencer #(
  parameter int unsigned POR_DELAY = mrs_pkg::POR_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic supply_rise,
  input wire logic watchdog_timeout,
  input wire logic clock_fail,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic bootstrap_mode,
  input wire logic test_mode,
  input wire logic expanded_mode,
  input wire logic watchdog_disable_cell,
  input wire logic [1:0] nv_map_enable,
  output logic [1:0] map_enable,
  output logic cpu_reset,
  output logic vector_fetch,
  output logic [15:0] vector_addr,
  output logic [15:0] start_addr,
  output mrs_pkg::mrs_periph_t periph,
  input wire mrs_pkg::mrs_axi_req_t axi_req,
  output mrs_pkg::mrs_axi_rsp_t axi_rsp
);
  // ********************************************
  // state record
  // ********************************************
  typedef struct packed {
    mrs_pkg::mrs_state_t state;
    logic [11:0] count;
    logic sync1;
    logic sync2;
    mrs_pkg::mrs_cause_t cause;
    logic [3:0] sw_ctrl;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic in_reset;
    logic [15:0] vector;
  } mrs_state_rec_t;

  mrs_state_rec_t cur;
  mrs_state_rec_t next_cur;
  logic sw_wdog;
  logic sw_clkmon;
  logic internal_src;
  logic special;
  logic wr_go;
  logic [15:0] cause_vector;

  assign sw_wdog = cur.sw_ctrl[mrs_pkg::CTRL_WDOG_BIT];
  assign sw_clkmon = cur.sw_ctrl[mrs_pkg::CTRL_CLKMON_BIT];
  assign special = bootstrap_mode | test_mode;
  // internal reset requests: hardware events or software test triggers
  assign internal_src = watchdog_timeout | clock_fail | sw_wdog | sw_clkmon;
  assign wr_go = axi_req.awvalid & axi_req.wvalid & ~cur.bvalid;

  // vector select from held cause, special modes move it into boot space
  always_comb
  begin
    unique case (cur.cause)
      mrs_pkg::CAUSE_WDOG:
        cause_vector = special ? mrs_pkg::VEC_WDOG_SPECIAL : mrs_pkg::VEC_WDOG;
      mrs_pkg::CAUSE_CLKMON:
        cause_vector = special ? mrs_pkg::VEC_CLKMON_SPECIAL : mrs_pkg::VEC_CLKMON;
      default:
        cause_vector = special ? mrs_pkg::VEC_SPECIAL : mrs_pkg::VEC_RESTART;
    endcase
  end

  // ********************************************
  // next-state logic
  // ********************************************
  always_comb
  begin
    next_cur = cur;
    // two-stage synchroniser; only sync2 is looked at
    next_cur.sync1 = reset_pin_in;
    next_cur.sync2 = cur.sync1;
    unique case (cur.state)
      mrs_pkg::ST_POR:
      begin
        // count from first oscillator activity; then wait for pin high
        if (cur.count >= 12'(POR_DELAY - 1))
        begin
          if (cur.sync2)
          begin
            next_cur.state = mrs_pkg::ST_FETCH;
            next_cur.count = '0;
            next_cur.vector = cause_vector;
          end
        end
        else
        begin
          next_cur.count = cur.count + 12'h001;
        end
      end
      mrs_pkg::ST_DRIVE:
      begin
        // pin held low by us for exactly four cycles
        if (cur.count == 12'(mrs_pkg::PIN_DRIVE_CYCLES - 4'h1))
        begin
          next_cur.state = mrs_pkg::ST_WAIT;
          next_cur.count = '0;
        end
        else
        begin
          next_cur.count = cur.count + 12'h001;
        end
      end
      mrs_pkg::ST_WAIT:
      begin
        // pin released; relies on the far side letting it rise in time
        // sync2 lags the pin by two cycles, so wait that much longer to see
        // the level two cycles after release rather than our own drive
        if (cur.count == 12'(mrs_pkg::PIN_SAMPLE_DELAY + mrs_pkg::SYNC_LATENCY - 4'h1))
        begin
          next_cur.count = '0;
          // low means external, high keeps the internal cause
          if (!cur.sync2)
          begin
            next_cur.cause = mrs_pkg::CAUSE_EXT;
            next_cur.state = mrs_pkg::ST_HOLD;
          end
          else
          begin
            next_cur.state = mrs_pkg::ST_FETCH;
            next_cur.vector = cause_vector;
          end
        end
        else
        begin
          next_cur.count = cur.count + 12'h001;
        end
      end
      mrs_pkg::ST_HOLD:
      begin
        // external reset: stay until the line is seen high
        if (cur.sync2)
        begin
          next_cur.state = mrs_pkg::ST_FETCH;
          next_cur.vector = special ? mrs_pkg::VEC_SPECIAL : mrs_pkg::VEC_RESTART;
        end
      end
      mrs_pkg::ST_FETCH:
      begin
        // reset vector chosen by the cause fetched in the first three cycles
        if (cur.count == 12'(mrs_pkg::VECTOR_CYCLES - 3'h1))
        begin
          next_cur.state = mrs_pkg::ST_RUN;
          next_cur.count = '0;
        end
        else
        begin
          next_cur.count = cur.count + 12'h001;
        end
      end
      mrs_pkg::ST_RUN:
      begin
        // any pin or internal source restarts the sequence with the pin drive; a supply rise goes to the power-on count instead
        if (!cur.sync2 || internal_src)
        begin
          next_cur.state = mrs_pkg::ST_DRIVE;
          next_cur.count = '0;
          // cause held until the next vector fetch
          if (clock_fail | sw_clkmon)
          begin
            next_cur.cause = mrs_pkg::CAUSE_CLKMON;
          end
          else if (watchdog_timeout | sw_wdog)
          begin
            next_cur.cause = mrs_pkg::CAUSE_WDOG;
          end
          else
          begin
            next_cur.cause = mrs_pkg::CAUSE_EXT;
          end
        end
      end
    endcase
    // power-on reset only on rising supply, never on a drop
    if (supply_rise)
    begin
      next_cur.state = mrs_pkg::ST_POR;
      next_cur.count = '0;
      next_cur.cause = mrs_pkg::CAUSE_POR;
    end
    next_cur.in_reset = (next_cur.state != mrs_pkg::ST_RUN);

    // axi4-lite slave; writes need both channels, trigger bits self-clear
    next_cur.sw_ctrl[1:0] = 2'b00;
    if (cur.bvalid && axi_req.bready)
    begin
      next_cur.bvalid = 1'b0;
    end
    if (wr_go)
    begin
      next_cur.bvalid = 1'b1;
      next_cur.bresp = mrs_pkg::RESP_OKAY;
      if (axi_req.awaddr == mrs_pkg::CTRL_OFFSET)
      begin
        if (axi_req.wstrb[0])
        begin
          next_cur.sw_ctrl = axi_req.wdata[3:0];
        end
      end
      else if (axi_req.awaddr != mrs_pkg::STATUS_OFFSET &&
               axi_req.awaddr != mrs_pkg::VECTOR_OFFSET &&
               axi_req.awaddr != mrs_pkg::INITV_OFFSET)
      begin
        next_cur.bresp = mrs_pkg::RESP_SLVERR;
      end
    end
    if (cur.rvalid && axi_req.rready)
    begin
      next_cur.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !cur.rvalid)
    begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp = mrs_pkg::RESP_OKAY;
      unique case (axi_req.araddr)
        mrs_pkg::CTRL_OFFSET: next_cur.rdata = {28'h0000000, cur.sw_ctrl};
        mrs_pkg::STATUS_OFFSET:
          next_cur.rdata = {24'h000000, cur.in_reset, cur.state, cur.sync2, cur.cause, 1'b0};
        mrs_pkg::VECTOR_OFFSET: next_cur.rdata = {16'h0000, cur.vector};
        mrs_pkg::INITV_OFFSET: next_cur.rdata = {24'h000000, mrs_pkg::INIT_RESET};
        default:
        begin
          next_cur.rdata = 32'h00000000;
          next_cur.rresp = mrs_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // register the state record; reset enters the power-on count
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cur <= '{state: mrs_pkg::ST_POR, cause: mrs_pkg::CAUSE_POR, sync1: 1'b1, sync2: 1'b1,
               in_reset: 1'b1, vector: mrs_pkg::VEC_RESTART, default: '0};
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // ********************************************
  // outputs
  // ********************************************
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = (cur.state == mrs_pkg::ST_DRIVE);
  assign cpu_reset = cur.in_reset;
  assign vector_fetch = (cur.state == mrs_pkg::ST_FETCH);
  assign vector_addr = cur.vector;
  // bootstrap runs from the boot rom once the vector is taken
  assign start_addr = bootstrap_mode ? mrs_pkg::BOOT_ROM_BASE : cur.vector;
  // nonvolatile enables pass straight through, reset never touches them
  assign map_enable = nv_map_enable;
  assign axi_rsp.awready = wr_go;
  assign axi_rsp.wready = wr_go;
  assign axi_rsp.bvalid = cur.bvalid;
  assign axi_rsp.bresp = cur.bresp;
  assign axi_rsp.arready = ~cur.rvalid;
  assign axi_rsp.rvalid = cur.rvalid;
  assign axi_rsp.rdata = cur.rdata;
  assign axi_rsp.rresp = cur.rresp;

  // forced peripheral levels while the controller sits in reset
  always_comb
  begin
    periph = '0;
    periph.ccr_x_mask = 1'b1;
    periph.ccr_i_mask = 1'b1;
    periph.stop_disable = 1'b1;
    periph.init_map = mrs_pkg::INIT_RESET;
    periph.expansion_bus = expanded_mode;
    periph.port_c_direction = mrs_pkg::PORTC_DIR_RESET;
    periph.strobe_a_edge_select = ~expanded_mode;
    periph.strobe_b_invert = ~expanded_mode;
    periph.timer_count = mrs_pkg::TIMER_COUNT_RESET;
    periph.compare_value = mrs_pkg::COMPARE_RESET;
    periph.timer_clear = cur.in_reset;
    periph.periodic_interrupt_clear = cur.in_reset;
    periph.pulse_input_enable = 1'b0;
    periph.watchdog_timer_enable = ~watchdog_disable_cell;
    periph.watchdog_rate = 2'b00;
    periph.sci_clear = cur.in_reset;
    periph.tx_buffer_empty = 1'b1;
    periph.tx_complete = 1'b1;
    periph.rx_clear = cur.in_reset;
    periph.spi_enable = 1'b0;
    periph.converter_power_up = 1'b0;
    periph.converter_done_clear = cur.in_reset;
  end

  // ********************************************
  // assertions
  // ********************************************
  pin_drive_len_a: assert property (@(posedge clk) disable iff (reset)
    $rose(reset_pin_oe) |-> reset_pin_oe [*4] ##1 !reset_pin_oe)
    else $error("reset pin not driven for four cycles");
  sample_point_a: assert property (@(posedge clk) disable iff (reset)
    ($fell(reset_pin_oe) && !supply_rise) ##1 (!supply_rise) [*2] ##1 (!cur.sync2 && !supply_rise)
      |=> cur.state == mrs_pkg::ST_HOLD)
    else $error("low pin after release not classed external");
  sample_high_a: assert property (@(posedge clk) disable iff (reset)
    ($fell(reset_pin_oe) && !supply_rise) ##1 (!supply_rise) [*2] ##1 (cur.sync2 && !supply_rise)
      |=> cur.state == mrs_pkg::ST_FETCH)
    else $error("high pin after release not classed internal");
  sync_delay_a: assert property (@(posedge clk) disable iff (reset)
    (!$past(reset) && !$past(reset, 2)) |-> cur.sync2 == $past(reset_pin_in, 2))
    else $error("pin not seen through two flip-flops");
  cause_kept_a: assert property (@(posedge clk) disable iff (reset)
    (vector_fetch && !supply_rise) |=> $stable(cur.cause))
    else $error("cause changed during vector fetch");
  por_pin_low_a: assert property (@(posedge clk) disable iff (reset)
    (cur.state == mrs_pkg::ST_POR && !cur.sync2 && !supply_rise) |=> cur.state == mrs_pkg::ST_POR)
    else $error("power-on left while pin low");
  fetch_len_a: assert property (@(posedge clk) disable iff (reset || supply_rise)
    $rose(vector_fetch) |-> vector_fetch [*3] ##1 !vector_fetch)
    else $error("vector fetch not three cycles");
  hold_low_a: assert property (@(posedge clk) disable iff (reset)
    (cur.state == mrs_pkg::ST_HOLD && !cur.sync2) |=> cpu_reset)
    else $error("left reset while pin low");
  wdog_vector_a: assert property (@(posedge clk) disable iff (reset)
    (vector_fetch && cur.cause == mrs_pkg::CAUSE_WDOG && !special)
      |-> vector_addr == mrs_pkg::VEC_WDOG)
    else $error("watchdog vector wrong");
  clkmon_drive_a: assert property (@(posedge clk) disable iff (reset || supply_rise)
    (cur.state == mrs_pkg::ST_RUN && clock_fail)
      |=> reset_pin_oe && cur.cause == mrs_pkg::CAUSE_CLKMON)
    else $error("clock monitor reset not on pin");
  source_reset_a: assert property (@(posedge clk) disable iff (reset)
    (cur.state == mrs_pkg::ST_RUN && watchdog_timeout) |=> cpu_reset)
    else $error("watchdog did not reset");
  por_start_a: assert property (@(posedge clk) disable iff (reset)
    supply_rise |=> cur.state == mrs_pkg::ST_POR && cur.count == 12'h000)
    else $error("power-on count not restarted");
  masks_set_a: assert property (@(posedge clk) disable iff (reset)
    cpu_reset |-> periph.ccr_i_mask && periph.ccr_x_mask && periph.stop_disable)
    else $error("masks not set in reset");
endmodule
`default_nettype wire

/* mrs_partner.sv */
// external reset supervisor model that pulls the reset line from outside
`default_nettype none
module mrs_partner (
  input wire logic clk,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic start,
  input wire logic [7:0] hold_cycles,
  input wire logic slow,
  output logic reset_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int left = 0;
  logic lag = 1'b0;
  // ************************************************
  // line level
  // ************************************************
  // the line has a pull-up, so it reads high once nobody pulls it down
  always_comb
  begin
    if (reset_pin_oe)
      reset_pin_in = reset_pin_out;
    else
      reset_pin_in = (left > 0 || lag) ? 1'b0 : 1'b1;
  end
  // never shorter than eight cycles; slow mode rises one cycle late
  always @(posedge clk)
  begin
    if (start)
      left <= (hold_cycles < 8'h08) ? 8 : int'(hold_cycles);
    else if (left > 0)
      left <= left - 1;
    lag <= slow && left == 1;
  end
endmodule
`default_nettype wire

/* test_mcu_reset_sequencer.sv */
// self-checking bench for the reset sequencer
`default_nettype none
module test_mcu_reset_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  // short power-on count keeps the run brief
  localparam int unsigned POR_N = 16;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic supply_rise = 1'b0;
  logic watchdog_timeout = 1'b0;
  logic clock_fail = 1'b0;
  logic bootstrap_mode = 1'b0;
  logic test_mode = 1'b0;
  logic expanded_mode = 1'b0;
  logic watchdog_disable_cell = 1'b0;
  logic [1:0] nv_map_enable = 2'h0;
  logic ext_start = 1'b0;
  logic [7:0] ext_len = 8'h08;
  logic ext_slow = 1'b0;
  logic reset_pin_in, reset_pin_out, reset_pin_oe, cpu_reset, vector_fetch;
  logic [1:0] map_enable;
  logic [15:0] vector_addr, start_addr;
  mrs_pkg::mrs_periph_t periph;
  mrs_pkg::mrs_axi_req_t req = '0;
  mrs_pkg::mrs_axi_rsp_t rsp, rsp_s;
  int n_mismatch = 0;
  int checks = 0;
  int seed = 55424;
  int cycles = 0;
  int drive_n = 0;
  int fetch_n = 0;

  mrs_sequencer #(.POR_DELAY(POR_N)) u_dut (
    .clk(clk), .reset(reset), .supply_rise(supply_rise),
    .watchdog_timeout(watchdog_timeout), .clock_fail(clock_fail),
    .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
    .reset_pin_oe(reset_pin_oe), .bootstrap_mode(bootstrap_mode), .test_mode(test_mode),
    .expanded_mode(expanded_mode), .watchdog_disable_cell(watchdog_disable_cell),
    .nv_map_enable(nv_map_enable), .map_enable(map_enable), .cpu_reset(cpu_reset),
    .vector_fetch(vector_fetch), .vector_addr(vector_addr), .start_addr(start_addr),
    .periph(periph), .axi_req(req), .axi_rsp(rsp)
  );
  mrs_partner u_far (
    .clk(clk), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .start(ext_start), .hold_cycles(ext_len), .slow(ext_slow), .reset_pin_in(reset_pin_in)
  );

  initial
  begin
    forever #2 clk = ~clk;
  end

  // ************************************************
  // checking helpers
  // ************************************************
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // sampled on the falling edge so nothing races the rising-edge updates
  always @(negedge clk)
  begin
    rsp_s <= rsp;
    cycles++;
    if (reset_pin_oe === 1'b1)
    begin
      drive_n++;
      chk("pin_level", 48'h0, reset_pin_out);
    end
    else if (drive_n != 0)
    begin
      chk("drive_len", 48'd4, 48'(drive_n));
      drive_n = 0;
    end
    if (vector_fetch === 1'b1)
      fetch_n++;
    // ceiling sits far above the few hundred cycles the episodes need
    if (cycles == 8000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  // ************************************************
  // bus master
  // ************************************************
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do @(posedge clk); while (rsp_s.awready !== 1'b1 || rsp_s.wready !== 1'b1);
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    do @(posedge clk); while (rsp_s.bvalid !== 1'b1);
    r = rsp_s.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do @(posedge clk); while (rsp_s.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk); while (rsp_s.rvalid !== 1'b1);
    d = rsp_s.rdata;
    r = rsp_s.rresp;
    req.rready <= 1'b0;
  endtask

  // reference model of the vector choice
  function automatic logic [15:0] exp_vec(input int cause, input logic special);
    case (cause)
      2: return special ? mrs_pkg::VEC_WDOG_SPECIAL : mrs_pkg::VEC_WDOG;
      3: return special ? mrs_pkg::VEC_CLKMON_SPECIAL : mrs_pkg::VEC_CLKMON;
      default: return special ? mrs_pkg::VEC_SPECIAL : mrs_pkg::VEC_RESTART;
    endcase
  endfunction

  // ************************************************
  // one reset episode: 0 pin, 1 power, 2 watchdog, 3 clock, 4/5 by register, 6 power with long pin
  // ************************************************
  task automatic run(input int kind);
    logic [1:0] r;
    logic [31:0] d;
    logic [15:0] v;
    int cause;
    int w;
    @(posedge clk);
    {bootstrap_mode, test_mode, expanded_mode, watchdog_disable_cell} <= 4'($random(seed));
    nv_map_enable <= 2'($random(seed));
    ext_len <= (kind == 6) ? 8'h28 : 8'h08 + 8'($random(seed) & 7);
    ext_slow <= 1'($random(seed));
    @(posedge clk);
    cause = (kind == 5) ? 3 : (kind == 4) ? 2 : kind;
    fetch_n = 0;
    ext_start <= kind == 0 || kind == 6;
    supply_rise <= kind == 1 || kind == 6;
    watchdog_timeout <= kind == 2;
    clock_fail <= kind == 3;
    if (kind >= 4 && kind < 6)
    begin
      axi_wr(mrs_pkg::CTRL_OFFSET, 32'(kind - 3), r);
      chk("bresp", mrs_pkg::RESP_OKAY, r);
    end
    @(posedge clk);
    {ext_start, supply_rise, watchdog_timeout, clock_fail} <= 4'h0;
    w = 0;
    while (cpu_reset !== 1'b1 && w < 20)
      @(negedge clk) w++;
    chk("cpu_map", {3'h7, mrs_pkg::INIT_RESET}, {periph.ccr_x_mask, periph.ccr_i_mask,
      periph.stop_disable, periph.init_map});
    chk("timer", {16'h0000, 16'hffff, 10'h000}, {periph.timer_count, periph.compare_value,
      periph.prescaler, periph.compare1_pin_mask});
    chk("port", {12'h000, {2{!expanded_mode}}, 8'h00, expanded_mode}, {periph.strobe_a_flag,
      periph.strobe_a_irq_enable, periph.handshake_select, periph.portc_open_drain,
      periph.port_c_direction, periph.strobe_a_edge_select, periph.strobe_b_invert,
      periph.port_b_out, periph.expansion_bus});
    chk("serial", {2'h3, 3'h0, !watchdog_disable_cell, 2'h0}, {periph.tx_buffer_empty,
      periph.tx_complete, periph.spi_enable, periph.pulse_input_enable,
      periph.converter_power_up, periph.watchdog_timer_enable, periph.watchdog_rate});
    // the line above
    chk("clears", 48'h3f, {cpu_reset, periph.timer_clear, periph.periodic_interrupt_clear,
      periph.sci_clear, periph.rx_clear, periph.converter_done_clear});
    if (kind == 6)
    begin
      repeat (POR_N + 8) @(negedge clk);
      chk("held", 48'h1, cpu_reset);
    end
    w = 0;
    while (vector_fetch !== 1'b1 && w < 300)
      @(negedge clk) w++;
    if (kind == 1)
      chk("por_long", 48'h1, w >= POR_N);
    v = exp_vec(cause, bootstrap_mode | test_mode);
    chk("vector", v, vector_addr);
    chk("start", bootstrap_mode ? mrs_pkg::BOOT_ROM_BASE : v, start_addr);
    while (vector_fetch === 1'b1 && w < 300)
      @(negedge clk) w++;
    chk("fetch_len", 48'd3, 48'(fetch_n));
    chk("clears_off", 48'h0, {cpu_reset, periph.timer_clear, periph.periodic_interrupt_clear,
      periph.sci_clear, periph.rx_clear, periph.converter_done_clear});
    chk("map", nv_map_enable, map_enable);
    axi_rd(mrs_pkg::STATUS_OFFSET, d, r);
    if (kind != 6)
      chk("cause", 48'(cause), d[2:1]);
    axi_rd(mrs_pkg::VECTOR_OFFSET, d, r);
    chk("vec_reg", {mrs_pkg::RESP_OKAY, v}, {r, d[15:0]});
  endtask

  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    // let the power-on count run out, or the first episode lands inside it
    repeat (POR_N + 8) @(negedge clk);
    chk("por_done", 48'h0, cpu_reset);
    for (int i = 0; i < 14; i++)
      run(i % 7);
    axi_rd(mrs_pkg::INITV_OFFSET, d, r);
    chk("init_reg", {mrs_pkg::RESP_OKAY, 32'h1}, {r, d});
    axi_rd(8'h10, d, r);
    chk("unmapped", {mrs_pkg::RESP_SLVERR, 32'h0}, {r, d});
    summarize();
  end
endmodule
`default_nettype wire
